// >>> core/rmx_pkg.sv
// Package: register map, field layout, unlock keys and bus types
package rmx_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RMX_OFF_LOCK_CFG = 8'h00;
  localparam logic [7:0] RMX_OFF_INSEL0 = 8'h04;
  localparam logic [7:0] RMX_OFF_INSEL1 = 8'h08;
  localparam logic [7:0] RMX_OFF_INSEL2 = 8'h0c;
  localparam logic [7:0] RMX_OFF_INSEL3 = 8'h10;
  localparam logic [7:0] RMX_OFF_INSEL4 = 8'h14;
  localparam logic [7:0] RMX_OFF_INSEL5 = 8'h18;
  localparam logic [7:0] RMX_OFF_UNLOCK = 8'h1c;
  localparam int RMX_NUM_SEL_REGS = 6;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int RMX_LOCK_BIT = 11;
  localparam int RMX_HI_LSB = 8;
  localparam int RMX_LO_LSB = 0;
  localparam int RMX_SEL_W = 8;
  localparam logic RMX_LOCK_RST = 1'b0;
  localparam logic [7:0] RMX_SEL_RST = 8'h00;
  // Lower byte implemented per select register (0..5)
  localparam logic [5:0] RMX_LO_IMPL = 6'b111010;

  // ----------------------------------------------------------------
  // Unlock sequence: two key words written back to back
  // ----------------------------------------------------------------
  localparam logic [15:0] RMX_KEY1 = 16'h55aa;
  localparam logic [15:0] RMX_KEY2 = 16'haa55;

  typedef enum logic [1:0] {
    RMX_UL_IDLE = 2'b00,
    RMX_UL_KEY1 = 2'b01,
    RMX_UL_OPEN = 2'b10
  } rmx_ul_state_t;

  // Latched AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } rmx_aphase_t;

  // One selector byte per peripheral input
  typedef struct packed {
    logic [7:0] irq_a;
    logic [7:0] irq_b;
    logic [7:0] irq_c;
    logic [7:0] tmr_clk;
    logic [7:0] cap_a;
    logic [7:0] ccp_tmr_a;
    logic [7:0] cap_b;
    logic [7:0] ccp_tmr_b;
    logic [7:0] cap_c;
    logic [7:0] ccp_tmr_c;
  } rmx_sel_t;

  // Routed peripheral input levels
  typedef struct packed {
    logic irq_a;
    logic irq_b;
    logic irq_c;
    logic tmr_clk;
    logic cap_a;
    logic ccp_tmr_a;
    logic cap_b;
    logic ccp_tmr_b;
    logic cap_c;
    logic ccp_tmr_c;
  } rmx_periph_t;

endpackage : rmx_pkg

// >>> core/rmx_unlock.sv
// Unlock sequencer that opens one write to the lock register
`timescale 1ns/1ps
module rmx_unlock
  import rmx_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic key_wr,
  input wire logic [15:0] key_data,
  input wire logic other_wr,
  input wire logic cfg_wr,
  output logic open
);

  rmx_ul_state_t state_r;
  rmx_ul_state_t state_nxt;

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Any other write breaks the sequence, so a stray store cannot
  // leave the lock register open behind software's back.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      RMX_UL_IDLE:
        if (key_wr && key_data == RMX_KEY1)
          state_nxt = RMX_UL_KEY1;
      RMX_UL_KEY1:
        if (key_wr && key_data == RMX_KEY2)
          state_nxt = RMX_UL_OPEN;
        else if (key_wr || other_wr || cfg_wr)
          state_nxt = RMX_UL_IDLE;
      RMX_UL_OPEN:
        if (key_wr || other_wr || cfg_wr)
          state_nxt = RMX_UL_IDLE;
      default:
        state_nxt = RMX_UL_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= RMX_UL_IDLE;
    else
      state_r <= state_nxt;
  end

  assign open = (state_r == RMX_UL_OPEN);

endmodule : rmx_unlock

// >>> core/rmx_xbar.sv
// Crossbar: one selector value picks one remappable pin level
`timescale 1ns/1ps
module rmx_xbar
  import rmx_pkg::*;
#(
  parameter int NUM_PINS = 64
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [NUM_PINS-1:0] remappable_pin,
  input wire rmx_sel_t sel,
  output rmx_periph_t periph
);

  // ----------------------------------------------------------------
  // Pin lookup
  // ----------------------------------------------------------------
  // Value N selects pin N; values past the last pin give a low level.
  function automatic logic pick(input logic [NUM_PINS-1:0] pins,
                                input logic [7:0] s);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_PINS; i++)
      if (s == 8'(i))
        r = pins[i];
    return r;
  endfunction : pick

  // Registered so each peripheral sees a clean flop output
  always_ff @(posedge clk)
  begin
    if (srst)
      periph <= '0;
    else
    begin
      periph.irq_a <= pick(remappable_pin, sel.irq_a);
      periph.irq_b <= pick(remappable_pin, sel.irq_b);
      periph.irq_c <= pick(remappable_pin, sel.irq_c);
      periph.tmr_clk <= pick(remappable_pin, sel.tmr_clk);
      periph.cap_a <= pick(remappable_pin, sel.cap_a);
      periph.ccp_tmr_a <= pick(remappable_pin, sel.ccp_tmr_a);
      periph.cap_b <= pick(remappable_pin, sel.cap_b);
      periph.ccp_tmr_b <= pick(remappable_pin, sel.ccp_tmr_b);
      periph.cap_c <= pick(remappable_pin, sel.cap_c);
      periph.ccp_tmr_c <= pick(remappable_pin, sel.ccp_tmr_c);
    end
  end

endmodule : rmx_xbar

// >>> core/rmx_top.sv
// Remappable input selectors with write lock behind an AHB-Lite slave
// Notes on behaviour
// - While the lock bit is one, writes to all remap registers are dropped.
// - While the lock bit is zero, remap registers take writes normally.
// - The lock register takes a write only right after the unlock keys.
// - Every lock-register bit except bit 11 reads as zero.
// - Select 0 holds the ext irq A selector in bits 15-8; bits 7-0 read 0.
// - Select 1 holds ext irq C in bits 15-8 and ext irq B in bits 7-0.
// - Select 2 holds the basic timer clock selector in 15-8; 7-0 read 0.
// - Select 3 routes capture A from bits 15-8, its timer from bits 7-0.
// - Select 4 routes capture B from bits 15-8, its timer from bits 7-0.
// - Select 5 routes capture C from bits 15-8, its timer from 7-0.
`timescale 1ns/1ps
module rmx_top
  import rmx_pkg::*;
#(
  parameter int NUM_PINS = 64
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_PINS-1:0] remappable_pin,
  output rmx_periph_t periph_in,
  output logic remap_write_lock
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rmx_aphase_t aph_r;
  logic [15:0] sel_r [RMX_NUM_SEL_REGS];
  logic lock_r;
  logic unlock_open;
  logic wr_dp;
  logic wr_key;
  logic wr_cfg;
  logic wr_sel;
  logic wr_other;
  logic [3:0] sel_code;
  logic [2:0] sel_idx;
  logic sel_hit;
  rmx_sel_t sel_bus;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] dec(input logic [7:0] a);
    logic [3:0] r;
    r = 4'hf;
    case (a)
      RMX_OFF_INSEL0: r = 4'h0;
      RMX_OFF_INSEL1: r = 4'h1;
      RMX_OFF_INSEL2: r = 4'h2;
      RMX_OFF_INSEL3: r = 4'h3;
      RMX_OFF_INSEL4: r = 4'h4;
      RMX_OFF_INSEL5: r = 4'h5;
      default: r = 4'hf;
    endcase
    return r;
  endfunction : dec

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      aph_r <= '0;
    else if (hready)
    begin
      aph_r.valid <= hsel && htrans[1];
      aph_r.write <= hwrite;
      aph_r.addr <= haddr[7:0];
    end
  end

  assign wr_dp = aph_r.valid && aph_r.write;
  assign wr_key = wr_dp && aph_r.addr == RMX_OFF_UNLOCK;
  assign wr_cfg = wr_dp && aph_r.addr == RMX_OFF_LOCK_CFG;
  assign sel_code = dec(aph_r.addr);
  assign sel_idx = sel_code[2:0];
  assign sel_hit = sel_code != 4'hf;
  assign wr_sel = wr_dp && sel_hit;
  // Any write that is neither a key nor the lock register breaks the
  // sequence, unmapped offsets included
  assign wr_other = wr_dp && !wr_key && !wr_cfg;

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  rmx_unlock u_unlock (
    .clk(clk),
    .srst(srst),
    .key_wr(wr_key),
    .key_data(hwdata[15:0]),
    .other_wr(wr_other),
    .cfg_wr(wr_cfg),
    .open(unlock_open)
  );

  // ----------------------------------------------------------------
  // Lock register
  // ----------------------------------------------------------------
  // A write without the keys is ignored silently; the bus still
  // answers OKAY so software must read back to confirm.
  always_ff @(posedge clk)
  begin
    if (srst)
      lock_r <= RMX_LOCK_RST;
    else if (wr_cfg && unlock_open)
      lock_r <= hwdata[RMX_LOCK_BIT];
  end

  assign remap_write_lock = lock_r;

  // ----------------------------------------------------------------
  // Selector registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < RMX_NUM_SEL_REGS; i++)
        sel_r[i] <= {RMX_SEL_RST, RMX_SEL_RST};
    end
    else if (wr_sel && !lock_r)
    begin
      sel_r[sel_idx][RMX_HI_LSB +: RMX_SEL_W] <=
        hwdata[RMX_HI_LSB +: RMX_SEL_W];
      // Unimplemented low bytes stay zero
      sel_r[sel_idx][RMX_LO_LSB +: RMX_SEL_W] <=
        RMX_LO_IMPL[sel_idx] ? hwdata[RMX_LO_LSB +: RMX_SEL_W]
                             : RMX_SEL_RST;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read mux uses the captured address; unmapped offsets read zero.
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (aph_r.valid && !aph_r.write)
    begin
      if (aph_r.addr == RMX_OFF_LOCK_CFG)
        hrdata[RMX_LOCK_BIT] = lock_r;
      else if (sel_hit)
        hrdata[15:0] = sel_r[sel_idx];
    end
  end

  // ----------------------------------------------------------------
  // Field routing
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_bus.irq_a = sel_r[0][RMX_HI_LSB +: RMX_SEL_W];
    sel_bus.irq_c = sel_r[1][RMX_HI_LSB +: RMX_SEL_W];
    sel_bus.irq_b = sel_r[1][RMX_LO_LSB +: RMX_SEL_W];
    sel_bus.tmr_clk = sel_r[2][RMX_HI_LSB +: RMX_SEL_W];
    sel_bus.cap_a = sel_r[3][RMX_HI_LSB +: RMX_SEL_W];
    sel_bus.ccp_tmr_a = sel_r[3][RMX_LO_LSB +: RMX_SEL_W];
    sel_bus.cap_b = sel_r[4][RMX_HI_LSB +: RMX_SEL_W];
    sel_bus.ccp_tmr_b = sel_r[4][RMX_LO_LSB +: RMX_SEL_W];
    sel_bus.cap_c = sel_r[5][RMX_HI_LSB +: RMX_SEL_W];
    sel_bus.ccp_tmr_c = sel_r[5][RMX_LO_LSB +: RMX_SEL_W];
  end

  rmx_xbar #(
    .NUM_PINS(NUM_PINS)
  ) u_xbar (
    .clk(clk),
    .srst(srst),
    .remappable_pin(remappable_pin),
    .sel(sel_bus),
    .periph(periph_in)
  );

endmodule : rmx_top

// >>> bench/rmx_pin_model.sv
// Pin-side model driving remappable pin levels
`timescale 1ns/1ps
module rmx_pin_model
(
  input wire logic clk,
  input wire logic [63:0] pat,
  output logic [63:0] pins
);
  // Pins move just after an edge, like synchronised pads
  always_ff @(posedge clk)
  begin
    pins <= pat;
  end
endmodule : rmx_pin_model

// >>> bench/rmx_asserts.sv
// Checker for bus answers and lock behaviour
`timescale 1ns/1ps
module rmx_asserts
  import rmx_pkg::*;
#(
  parameter int NUM_PINS = 64
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [NUM_PINS-1:0] remappable_pin,
  input wire rmx_periph_t periph_in,
  input wire logic remap_write_lock
);
  logic dp_rd_r;
  logic dp_wr_r;
  logic [7:0] dp_a_r;
  always_ff @(posedge clk)
  begin
    dp_rd_r <= !srst && hsel && htrans[1] && hready && !hwrite;
    dp_wr_r <= !srst && hsel && htrans[1] && hready && hwrite;
    if (hsel && htrans[1] && hready)
    begin
      dp_a_r <= haddr[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Lock held, then pins steady: selectors cannot have moved
  sequence s_locked;
    remap_write_lock ##1 $stable(remappable_pin);
  endsequence
  property p_locked_hold;
    s_locked |=> $stable(periph_in);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("routing moved while locked");
  property p_lock_src;
    $changed(remap_write_lock) |-> $past(dp_wr_r && dp_a_r == 8'h00);
  endproperty
  a_lock_src: assert property (p_lock_src)
    else $error("lock moved without a config write");
  property p_lock_val;
    $changed(remap_write_lock) |-> remap_write_lock == $past(hwdata[11]);
  endproperty
  a_lock_val: assert property (p_lock_val)
    else $error("lock differs from written bit");
  property p_cfg_rd;
    dp_rd_r && dp_a_r == RMX_OFF_LOCK_CFG
      |-> hrdata == {20'h0, remap_write_lock, 11'h0};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("config readback wrong");
  property p_lo_zero;
    dp_rd_r && (dp_a_r == RMX_OFF_INSEL0 || dp_a_r == RMX_OFF_INSEL2)
      |-> hrdata[7:0] == 8'h00 && hrdata[31:16] == 16'h0;
  endproperty
  a_lo_zero: assert property (p_lo_zero)
    else $error("unimplemented byte not zero");
  property p_rst;
    disable iff (1'b0) srst |=> !remap_write_lock && periph_in == '0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
  property p_idle;
    !dp_rd_r |-> hrdata == 32'h0 && hresp == 1'b0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside read phase");
  property p_unmapped;
    dp_rd_r && dp_a_r > RMX_OFF_UNLOCK |-> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule : rmx_asserts

// >>> bench/remap_input_select_lock_tb.sv
// Testbench for the remap selector block
`timescale 1ns/1ps
module remap_input_select_lock_tb;
  import rmx_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [63:0] pat = 0;
  logic hreadyout, hresp, lock;
  logic [31:0] hrdata;
  logic [63:0] pins;
  rmx_periph_t pin_lv;
  int n_mismatch = 0;
  int compares = 0;
  localparam logic [7:0] OFFS [7] = '{RMX_OFF_LOCK_CFG, RMX_OFF_INSEL0,
    RMX_OFF_INSEL1, RMX_OFF_INSEL2, RMX_OFF_INSEL3, RMX_OFF_INSEL4,
    RMX_OFF_INSEL5};
  always #5 clk = ~clk;
  rmx_pin_model pm_u (.clk(clk), .pat(pat), .pins(pins));
  rmx_top #(.NUM_PINS(64)) dut_u (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .remappable_pin(pins),
    .periph_in(pin_lv), .remap_write_lock(lock));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Address held until hready, then data held until hready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 16'h0, x);
    chk(x, e);
  endtask : rd_chk
  task automatic unl;
    wr(RMX_OFF_UNLOCK, RMX_KEY1);
    wr(RMX_OFF_UNLOCK, RMX_KEY2);
  endtask : unl
  task automatic t_reset;
    for (int i = 0; i < 7; i++) rd_chk(OFFS[i], 32'h0);
    chk({31'h0, lock}, 32'h0);
  endtask : t_reset
  task automatic t_rw;
    logic [15:0] v;
    for (int i = 1; i < 7; i++) wr(OFFS[i], 16'ha5c3 ^ 16'(i));
    wr(RMX_OFF_LOCK_CFG, 16'hffff);
    rd_chk(RMX_OFF_LOCK_CFG, 32'h0);
    for (int i = 1; i < 7; i++)
    begin
      v = 16'ha5c3 ^ 16'(i);
      if (i == 1 || i == 3) v[7:0] = 8'h00;
      rd_chk(OFFS[i], {16'h0, v});
    end
  endtask : t_rw
  task automatic t_route;
    rmx_periph_t e;
    wr(RMX_OFF_INSEL0, 16'h0300);
    wr(RMX_OFF_INSEL1, 16'h0a14);
    wr(RMX_OFF_INSEL2, 16'h2100);
    wr(RMX_OFF_INSEL3, 16'h283f);
    wr(RMX_OFF_INSEL4, 16'h5000);
    wr(RMX_OFF_INSEL5, 16'h073e);
    for (int k = 0; k < 2; k++)
    begin
      pat <= k ? 64'h3fff_fefd_ffef_fb76 : 64'hc000_0102_0010_0489;
      repeat (3) @(posedge clk);
      e = '{pat[3], pat[20], pat[10], pat[33], pat[40], pat[63], 1'b0,
            pat[0], pat[7], pat[62]};
      chk({22'h0, pin_lv}, {22'h0, e});
    end
  endtask : t_route
  task automatic t_lock;
    unl();
    wr(RMX_OFF_LOCK_CFG, 16'h0800);
    @(posedge clk);
    chk({31'h0, lock}, 32'h1);
    rd_chk(RMX_OFF_LOCK_CFG, 32'h800);
    wr(RMX_OFF_INSEL3, 16'h0101);
    rd_chk(RMX_OFF_INSEL3, 32'h283f);
    rd_chk(8'h20, 32'h0);
    // A write between the keys must cancel the opening
    wr(RMX_OFF_UNLOCK, RMX_KEY1);
    wr(RMX_OFF_INSEL1, 16'h0000);
    wr(RMX_OFF_UNLOCK, RMX_KEY2);
    wr(RMX_OFF_LOCK_CFG, 16'h0000);
    @(posedge clk);
    chk({31'h0, lock}, 32'h1);
    unl();
    wr(RMX_OFF_LOCK_CFG, 16'h0000);
    wr(RMX_OFF_INSEL3, 16'h0101);
    rd_chk(RMX_OFF_INSEL3, 32'h0101);
    // A stray write to an unmapped offset also closes the opening
    unl();
    wr(8'h20, 16'h0000);
    wr(RMX_OFF_LOCK_CFG, 16'h0800);
    @(posedge clk);
    chk({31'h0, lock}, 32'h0);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_chk(RMX_OFF_INSEL3, 32'h0);
  endtask : t_lock
  task automatic wrap_up;
    $display("n_mismatch %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  initial
  begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rw();
    t_route();
    t_lock();
    wrap_up();
  end
endmodule : remap_input_select_lock_tb
bind rmx_top rmx_asserts #(.NUM_PINS(NUM_PINS)) chk_u (.clk(clk),
  .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hresp(hresp),
  .hrdata(hrdata), .remappable_pin(remappable_pin),
  .periph_in(periph_in), .remap_write_lock(remap_write_lock));
